// >>> rtl/crf_pkg.sv
// constants and types for the conversion-rate and fan pwm register bank
// Summary of operation
// RULE1: rate code 0..9 picks 0.05 Hz up to 26 Hz; resets to 8 (13 Hz).
// RULE2: rate codes above 9 behave exactly like code 9, 26 Hz.
// RULE3: rate register bits 7:4 ignore writes and read back as zero.
// RULE4: in standby a one-shot write runs one full conversion, then idles.
// RULE5: one-shot register is write-only; any data value triggers.
// RULE6: standard pwm mode uses six-bit duty scaled by the frequency field.
// RULE7: pwm frequency field zero behaves exactly like one.
// RULE8: pwm period is twice frequency in ticks; duty saturates at full scale.
package crf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV_RATE = 8'h04;
  localparam logic [7:0] ADDR_CONV_RATE_ALT = 8'h0a;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;
  localparam logic [7:0] ADDR_PWM_DUTY = 8'h4c;
  localparam logic [7:0] ADDR_PWM_FREQ = 8'h4d;
  localparam logic [7:0] ADDR_MAKER = 8'hfe;
  localparam logic [7:0] ADDR_REVISION = 8'hff;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CONV_CODE_W = 4;
  localparam int PWM_FREQ_W = 5;
  localparam int PWM_DUTY_W = 6;
  localparam int NUM_RATES = 10;
  localparam logic [3:0] CONV_CODE_RESET = 4'h8;
  localparam logic [3:0] CONV_CODE_MAX = 4'h9;
  localparam logic [3:0] CONV_PAD_ZERO = 4'h0;
  localparam logic [4:0] PWM_FREQ_RESET = 5'h08;
  localparam logic [4:0] PWM_FREQ_ZERO = 5'h00;
  localparam logic [4:0] PWM_FREQ_ONE = 5'h01;
  localparam logic [5:0] PWM_DUTY_RESET = 6'h00;
  localparam logic [1:0] PWM_PAD2 = 2'h0;
  localparam logic [2:0] PWM_PAD3 = 3'h0;
  // arbitrary identity values, not those of any real part
  localparam logic [7:0] MAKER_CODE_DEF = 8'h5a;
  localparam logic [7:0] REVISION_CODE_DEF = 8'h3c;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ_DEF = 20_000_000;
  localparam int PWM_TICK_HZ = 360_000;
  localparam longint MHZ_PER_HZ = 1000;
  // conversion rates in millihertz, indexed by rate code
  localparam int RATE_MHZ [NUM_RATES] = '{50, 100, 204, 406, 813,
                                          1625, 3250, 6500, 13000, 26000};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } crf_state_t;

  // cycles per conversion period, rounded down
  function automatic logic [31:0] crf_period_cycles(input int clk_hz,
                                                     input int idx);
    longint p;
    p = (longint'(clk_hz) * MHZ_PER_HZ) / longint'(RATE_MHZ[idx]);
    return p[31:0];
  endfunction
endpackage

// >>> rtl/crf_pwm_if.sv
// carrier between the register bank and its pwm generator
`timescale 1ns/1ps
`default_nettype none
interface crf_pwm_if;
  logic [4:0] freq;
  logic [5:0] duty;
  logic pwm_level;
  modport ctrl(output freq, output duty, input pwm_level);
  modport gen(input freq, input duty, output pwm_level);
endinterface
`default_nettype wire

// >>> rtl/crf_pwm_gen.sv
// standard-resolution fan pwm generator
`timescale 1ns/1ps
`default_nettype none
module crf_pwm_gen
  import crf_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  crf_pwm_if.gen pwm
);
  localparam int TICK_DIV = CLK_HZ / PWM_TICK_HZ;
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);
  localparam logic [5:0] ONE6 = 6'h01;

  logic [15:0] pre, next_pre;
  logic [5:0] cnt, next_cnt;
  logic next_level;
  logic level;
  logic tick;
  logic [4:0] freq_eff;
  logic [5:0] period;
  logic [5:0] active;

  // ---------------------------------------------------------------
  // period and duty mapping
  // ---------------------------------------------------------------
  always_comb begin
    freq_eff = (pwm.freq == PWM_FREQ_ZERO) ? PWM_FREQ_ONE : pwm.freq; // [RULE7]
    period = {freq_eff, 1'b0}; // [RULE8]
    active = (pwm.duty > period) ? period : pwm.duty; // [RULE6] [RULE8]
  end

  // ---------------------------------------------------------------
  // tick prescaler and period counter
  // ---------------------------------------------------------------
  always_comb begin
    tick = (pre == TICK_LAST);
    next_pre = tick ? 16'h0000 : pre + 16'h0001;
    next_cnt = cnt;
    if (tick) begin
      next_cnt = (cnt >= period - ONE6) ? 6'h00 : cnt + ONE6; // [RULE8]
    end
    next_level = (cnt < active); // [RULE8]
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre <= 16'h0000;
      cnt <= 6'h00;
      level <= 1'b0;
    end else begin
      pre <= next_pre;
      cnt <= next_cnt;
      level <= next_level;
    end
  end

  assign pwm.pwm_level = level;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  a_pwm_wrap: assert property ( // [RULE8]
    tick && cnt >= period - ONE6 |=> cnt == 6'h00)
    else $error("pwm counter did not wrap at end of period");
  a_freq_zero_map: assert property ( // [RULE7]
    pwm.freq == PWM_FREQ_ZERO |-> period == 6'h02)
    else $error("frequency zero not treated as one");
  a_duty_saturate: assert property ( // [RULE6]
    pwm.duty >= period && cnt < period && $stable(period) &&
    $stable(pwm.duty) |=> level)
    else $error("saturated duty did not hold output active");
  a_duty_zero: assert property (pwm.duty == 6'h00 |=> !level) // [RULE8]
    else $error("zero duty produced an active output");
endmodule
`default_nettype wire

// >>> rtl/crf_regs.sv
// conversion-rate, one-shot, id and fan pwm register bank
`timescale 1ns/1ps
`default_nettype none
module crf_regs
  import crf_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF,
  parameter logic [7:0] MAKER_CODE = MAKER_CODE_DEF,
  parameter logic [7:0] REVISION_CODE = REVISION_CODE_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_standby,
  input wire logic i_conv_done,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output logic o_conv_start,
  output logic o_busy,
  output logic o_fan_pwm
);
  crf_pwm_if pwm_bus ();

  logic [31:0] period_tab [NUM_RATES];
  logic [3:0] conv_code, next_conv_code;
  logic [5:0] duty, next_duty;
  logic [4:0] freq, next_freq;
  logic [7:0] next_rdata;
  logic next_rd_valid;
  logic oneshot_pend, next_oneshot_pend;
  logic [31:0] timer, next_timer;
  logic [31:0] period_sel;
  logic due;
  crf_state_t state, next_state;
  logic next_conv_start;
  logic wr_rate, wr_oneshot;

  // ---------------------------------------------------------------
  // conversion period table
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_RATES; i++) begin : g_rate
    assign period_tab[i] = crf_period_cycles(CLK_HZ, i); // [RULE1]
  end

  always_comb begin
    if (conv_code > CONV_CODE_MAX) begin
      period_sel = period_tab[CONV_CODE_MAX]; // [RULE2]
    end else begin
      period_sel = period_tab[conv_code]; // [RULE1]
    end
  end

  // ---------------------------------------------------------------
  // register writes and reads
  // ---------------------------------------------------------------
  always_comb begin
    wr_rate = i_wr_en && (i_addr == ADDR_CONV_RATE ||
                          i_addr == ADDR_CONV_RATE_ALT);
    wr_oneshot = i_wr_en && (i_addr == ADDR_ONE_SHOT); // [RULE5]
    next_conv_code = wr_rate ? i_wdata[3:0] : conv_code; // [RULE3]
    next_duty = duty;
    next_freq = freq;
    if (i_wr_en && i_addr == ADDR_PWM_DUTY) begin
      next_duty = i_wdata[5:0]; // [RULE6]
    end
    if (i_wr_en && i_addr == ADDR_PWM_FREQ) begin
      next_freq = i_wdata[4:0];
    end
    next_rd_valid = i_rd_en;
    next_rdata = o_rdata;
    if (i_rd_en) begin
      case (i_addr)
        ADDR_CONV_RATE, ADDR_CONV_RATE_ALT: begin
          next_rdata = {CONV_PAD_ZERO, conv_code}; // [RULE3]
        end
        ADDR_PWM_DUTY: next_rdata = {PWM_PAD2, duty};
        ADDR_PWM_FREQ: next_rdata = {PWM_PAD3, freq};
        ADDR_MAKER: next_rdata = MAKER_CODE;
        ADDR_REVISION: next_rdata = REVISION_CODE;
        default: next_rdata = RDATA_UNMAPPED; // [RULE5]
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      conv_code <= CONV_CODE_RESET; // [RULE1]
      duty <= PWM_DUTY_RESET;
      freq <= PWM_FREQ_RESET;
      o_rdata <= RDATA_UNMAPPED;
      o_rd_valid <= 1'b0;
    end else begin
      conv_code <= next_conv_code;
      duty <= next_duty;
      freq <= next_freq;
      o_rdata <= next_rdata;
      o_rd_valid <= next_rd_valid;
    end
  end

  // ---------------------------------------------------------------
  // conversion scheduler
  // ---------------------------------------------------------------
  always_comb begin
    due = (timer >= period_sel - 32'h1);
    next_timer = (i_standby || due) ? 32'h0 : timer + 32'h1;
    next_oneshot_pend = oneshot_pend;
    next_state = state;
    next_conv_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (oneshot_pend || (due && !i_standby)) begin
          next_conv_start = 1'b1; // [RULE4]
          next_state = ST_BUSY;
          next_oneshot_pend = 1'b0;
        end
      end
      ST_BUSY: begin
        if (i_conv_done) begin
          next_state = ST_IDLE; // [RULE4]
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (wr_oneshot && i_standby) begin
      next_oneshot_pend = 1'b1; // [RULE4] [RULE5]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer <= 32'h0;
      oneshot_pend <= 1'b0;
      state <= ST_IDLE;
      o_conv_start <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      timer <= next_timer;
      oneshot_pend <= next_oneshot_pend;
      state <= next_state;
      o_conv_start <= next_conv_start;
      o_busy <= (next_state == ST_BUSY);
    end
  end

  // ---------------------------------------------------------------
  // fan pwm
  // ---------------------------------------------------------------
  assign pwm_bus.freq = freq;
  assign pwm_bus.duty = duty;
  assign o_fan_pwm = pwm_bus.pwm_level;

  crf_pwm_gen #(
    .CLK_HZ(CLK_HZ)
  ) u_pwm (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .pwm(pwm_bus)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_oneshot_trig;
    i_wr_en && i_addr == ADDR_ONE_SHOT && i_standby &&
      state == ST_IDLE && !oneshot_pend && !i_conv_done;
  endsequence
  sequence s_single_start;
    o_conv_start ##1 (!o_conv_start && o_busy);
  endsequence

  a_oneshot_start: assert property ( // [RULE4]
    s_oneshot_trig |-> ##2 s_single_start)
    else $error("one-shot write did not start exactly one conversion");
  a_oneshot_any_data: assert property (s_oneshot_trig |=> oneshot_pend) // [RULE5]
    else $error("one-shot write was not taken as a trigger");
  a_busy_release: assert property ( // [RULE4]
    o_busy && state == ST_BUSY && i_conv_done |=> !o_busy)
    else $error("device not idle after conversion done");
  a_standby_quiet: assert property ( // [RULE4]
    i_standby && !oneshot_pend |=> !o_conv_start)
    else $error("conversion started in standby without trigger");
  a_rate_write: assert property ( // [RULE1]
    wr_rate |=> conv_code == $past(i_wdata[3:0]))
    else $error("rate code not stored");
  a_rate_upper_zero: assert property ( // [RULE3]
    o_rd_valid && ($past(i_addr) == ADDR_CONV_RATE) |->
      o_rdata[7:4] == CONV_PAD_ZERO)
    else $error("rate register upper bits not zero");
  a_rate_clamp: assert property ( // [RULE2]
    conv_code > CONV_CODE_MAX |->
      period_sel == crf_period_cycles(CLK_HZ, CONV_CODE_MAX))
    else $error("out-of-range rate code not clamped to fastest");
  a_rate_timed: assert property ( // [RULE1]
    !i_standby && state == ST_IDLE && !oneshot_pend && due |=>
      o_conv_start)
    else $error("periodic conversion not started when due");
endmodule
`default_nettype wire

// >>> verif/crf_conv_model.sv
// conversion datapath model answering each start with a done pulse
`timescale 1ns/1ps
`default_nettype none
module crf_conv_model #(
  parameter int DELAY = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_start,
  output logic o_done
);
  // ---------------------------------------------------------------
  // countdown from start to done
  // ---------------------------------------------------------------
  int cnt;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 1);
      if (i_start) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/conversion_rate_and_fan_pwm_regs_tb.sv
// self-checking bench for the conversion-rate and fan pwm register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  n_errors++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module conversion_rate_and_fan_pwm_regs_tb;
  import crf_pkg::*;
  // ---------------------------------------------------------------
  // clock, reset, wiring
  // ---------------------------------------------------------------
  localparam int CLK = 360_000;
  localparam int CEIL = 80_000;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_standby = 1'b1;
  logic i_conv_done;
  logic [7:0] o_rdata;
  logic o_rd_valid;
  logic o_conv_start;
  logic o_busy;
  logic o_fan_pwm;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] d;
  always #25 i_clk_sys = ~i_clk_sys;
  crf_regs #(.CLK_HZ(CLK)) uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_standby(i_standby), .i_conv_done(i_conv_done),
    .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .o_conv_start(o_conv_start), .o_busy(o_busy), .o_fan_pwm(o_fan_pwm));
  crf_conv_model #(.DELAY(6)) conv (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_start(o_conv_start), .o_done(i_conv_done));
  // ---------------------------------------------------------------
  // bus tasks and closing
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, o_rd_valid)
    v = o_rdata;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_map();
    `CHK("busy", 1'b0, o_busy)
    `CHK("pwm", 1'b0, o_fan_pwm)
    rd(ADDR_CONV_RATE, d);
    `CHK("rate_reset", 8'h08, d)
    rd(ADDR_MAKER, d);
    `CHK("maker", MAKER_CODE_DEF, d)
    rd(ADDR_REVISION, d);
    `CHK("revision", REVISION_CODE_DEF, d)
    rd(ADDR_ONE_SHOT, d);
    `CHK("one_shot_rd", 8'h00, d)
    rd(8'h33, d);
    `CHK("unmapped", 8'h00, d)
    $display("test reset_map done");
  endtask
  task automatic t_rate_field();
    wr(ADDR_CONV_RATE, 8'hf3);
    rd(ADDR_CONV_RATE, d);
    `CHK("rate_hi_drop", 8'h03, d)
    wr(ADDR_CONV_RATE_ALT, 8'ha6);
    rd(ADDR_CONV_RATE, d);
    `CHK("rate_alias", 8'h06, d)
    $display("test rate_field done");
  endtask
  task automatic t_mid_reset();
    wr(ADDR_CONV_RATE, 8'h02);
    @(posedge i_clk_sys);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    `CHK("busy_rst", 1'b0, o_busy)
    rd(ADDR_CONV_RATE, d);
    `CHK("rate_rst", 8'h08, d)
    $display("test mid_reset done");
  endtask
  task automatic t_one_shot(input logic [7:0] v);
    int n;
    wr(ADDR_ONE_SHOT, v);
    #1;
    `CHK("start_c1", 1'b0, o_conv_start)
    @(posedge i_clk_sys);
    #1;
    `CHK("start_c2", 1'b1, o_conv_start)
    `CHK("busy_c2", 1'b1, o_busy)
    @(posedge i_clk_sys);
    #1;
    `CHK("start_c3", 1'b0, o_conv_start)
    n = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge i_clk_sys);
      #1;
      if (o_conv_start) n++;
    end
    `CHK("busy_end", 1'b0, o_busy)
    `CHK("extra_starts", 0, n)
    $display("test one_shot done");
  endtask
  task automatic t_rate(input logic [3:0] code);
    int per;
    int n;
    per = (CLK * 1000) / RATE_MHZ[9];
    wr(ADDR_CONV_RATE, {4'h0, code});
    i_standby <= 1'b0;
    for (n = 0; n < per + 10 && !o_conv_start; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (!o_conv_start && n < per + 10);
    `CHK("period", per, n)
    @(posedge i_clk_sys);
    i_standby <= 1'b1;
    $display("test rate done");
  endtask
  task automatic t_pwm(input logic [4:0] f, input logic [5:0] dt);
    int eff;
    int hi;
    eff = (f == 0) ? 1 : f;
    wr(ADDR_PWM_FREQ, {3'h0, f});
    wr(ADDR_PWM_DUTY, {2'h0, dt});
    rd(ADDR_PWM_FREQ, d);
    `CHK("freq_rd", {3'h0, f}, d)
    rd(ADDR_PWM_DUTY, d);
    `CHK("duty_rd", {2'h0, dt}, d)
    repeat (20) @(posedge i_clk_sys);
    hi = 0;
    for (int i = 0; i < 16 * eff; i++) begin
      @(posedge i_clk_sys);
      #1;
      if (o_fan_pwm === 1'b1) hi++;
    end
    `CHK("pwm_high", 8 * ((dt < 2 * eff) ? dt : 2 * eff), hi)
    $display("test pwm done");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    t_reset_map();
    t_rate_field();
    t_mid_reset();
    t_one_shot(8'ha5);
    t_one_shot(8'h00);
    t_rate(4'h9);
    t_rate(4'hf);
    t_pwm(5'h00, 6'h01);
    t_pwm(5'h01, 6'h01);
    t_pwm(5'h03, 6'h05);
    t_pwm(5'h02, 6'h3f);
    t_pwm(5'h08, 6'h0c);
    tally_and_finish();
  end
endmodule
`default_nettype wire
